// ### hw/dpd_pkg.sv
/*
 package for the dual pot serial command decoder: opcodes, frame counts, field positions, timing.
 assumes a 20 MHz reference clock and a serial link clock from the host.
*/
package dpd_pkg;
    localparam int unsigned REF_CLK_HZ = 20_000_000;
    localparam int unsigned NV_WR_TIME_US = 5000;
    localparam int unsigned NV_WR_CYCLES = NV_WR_TIME_US * (REF_CLK_HZ / 1_000_000);
    localparam int unsigned NUM_POTS = 2;
    localparam int unsigned NUM_SETTINGS = 4;
    localparam int unsigned WIPER_W = 6;
    localparam logic [5:0] WIPER_MAX = 6'h3F;
    localparam logic [5:0] WIPER_MIN = 6'h00;
    localparam logic [5:0] WIPER_STEP = 6'h01;
    localparam logic [5:0] STORED_RESET = 6'h20;
    localparam logic [5:0] DEVICE_CODE = 6'h14;
    // bit counter values, counted in received bits
    localparam logic [4:0] CNT_ADDR_LAST = 5'h07;
    localparam logic [4:0] CNT_INSTR_LAST = 5'h0F;
    localparam logic [4:0] CNT_INSTR_DONE = 5'h10;
    localparam logic [4:0] CNT_DATA_LAST = 5'h17;
    localparam logic [4:0] CNT_DATA_DONE = 5'h18;
    localparam logic [4:0] CNT_SAT = 5'h1F;
    // instruction byte fields
    localparam int unsigned OP_MSB = 7;
    localparam int unsigned OP_LSB = 4;
    localparam int unsigned IDX_MSB = 3;
    localparam int unsigned IDX_LSB = 2;
    localparam int unsigned ZERO_BIT = 1;
    localparam int unsigned POT_BIT = 0;
    localparam logic [2:0] PTR_ZERO3 = 3'h0;
    localparam logic [1:0] PTR_ZERO2 = 2'h0;
    localparam logic [3:0] STATUS_PTR = 4'h1;
    typedef enum logic [3:0] {
        OP_GXFR_S2W = 4'h1,
        OP_STEP = 4'h2,
        OP_STATUS = 4'h5,
        OP_GXFR_W2S = 4'h8,
        OP_RD_WIPER = 4'h9,
        OP_WR_WIPER = 4'hA,
        OP_RD_SET = 4'hB,
        OP_WR_SET = 4'hC,
        OP_XFR_S2W = 4'hD,
        OP_XFR_W2S = 4'hE
    } dpd_op_t;

    // reserved pointer bits must hold their fixed pattern
    function automatic logic dpd_instr_ok(input logic [7:0] instr);
        logic ok;
        ok = 1'b0;
        case (instr[OP_MSB:OP_LSB])
            OP_RD_WIPER, OP_WR_WIPER, OP_STEP: ok = (instr[IDX_MSB:POT_BIT+1] == PTR_ZERO3);
            OP_RD_SET, OP_WR_SET, OP_XFR_S2W, OP_XFR_W2S: ok = !instr[ZERO_BIT];
            OP_GXFR_S2W, OP_GXFR_W2S: ok = (instr[ZERO_BIT:POT_BIT] == PTR_ZERO2);
            OP_STATUS: ok = (instr[IDX_MSB:POT_BIT] == STATUS_PTR);
            default: ok = 1'b0;
        endcase
        return ok;
    endfunction : dpd_instr_ok

    // two-byte frames that act once chip select rises
    function automatic logic dpd_is_xfer(input dpd_op_t op);
        return (op == OP_XFR_S2W) || (op == OP_XFR_W2S) || (op == OP_GXFR_S2W) || (op == OP_GXFR_W2S);
    endfunction : dpd_is_xfer

    function automatic logic dpd_is_read(input dpd_op_t op);
        return (op == OP_RD_WIPER) || (op == OP_RD_SET) || (op == OP_STATUS);
    endfunction : dpd_is_read
endpackage : dpd_pkg

// ### hw/dpd_sync.sv
/*
 two flip-flop level synchroniser of parameterised width.
 assumes each bit is a level or a word that is held stable while it is read.
*/
`timescale 1ns/1ns
module dpd_sync #(
    parameter int unsigned W = 1
) (
    input wire logic i_clk,
    input wire logic [W-1:0] i_d,
    output logic [W-1:0] o_q
);
    logic [W-1:0] meta_q;

    always_ff @(posedge i_clk) begin
        meta_q <= i_d;
        o_q <= meta_q;
    end
endmodule : dpd_sync

// ### hw/dpd_nv_timer.sv
/*
 nonvolatile write cycle timer: busy for a fixed number of reference clocks after a start pulse.
 assumes start is a one-cycle pulse on the reference clock.
*/
`timescale 1ns/1ns
module dpd_nv_timer #(
    parameter int unsigned CYCLES = 100000
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_start,
    output logic o_busy
);
    localparam int unsigned CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LAST = CW'(CYCLES - 1);
    logic [CW-1:0] cnt_q;

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            cnt_q <= '0;
            o_busy <= 1'b0;
        end else if (i_start && !o_busy) begin
            cnt_q <= '0;
            o_busy <= 1'b1;
        end else if (o_busy) begin
            cnt_q <= cnt_q + CW'(1);
            if (cnt_q == LAST) begin
                o_busy <= 1'b0;
            end
        end
    end

    // checks
    logic [31:0] busy_cnt_q;
    always_ff @(posedge i_ref_clk) begin
        if (i_rst || !o_busy) begin
            busy_cnt_q <= 32'h0000_0000;
        end else begin
            busy_cnt_q <= busy_cnt_q + 32'h0000_0001;
        end
    end

    sequence s_nv_cycle;
        i_start ##1 o_busy;
    endsequence

    property p_nv_busy;
        @(posedge i_ref_clk) disable iff (i_rst) (i_start && !o_busy) |-> s_nv_cycle;
    endproperty
    a_nv_busy: assert property (p_nv_busy) else $error("busy not set by write cycle");

    property p_nv_max;
        @(posedge i_ref_clk) disable iff (i_rst) busy_cnt_q <= CYCLES;
    endproperty
    a_nv_max: assert property (p_nv_max) else $error("write cycle too long");
endmodule : dpd_nv_timer

// ### hw/dpd_top.sv
/*
 command decoder of a two channel 64 step digital pot: serial frame decode on the link clock,
 wiper and stored setting registers and the nonvolatile write cycle on the reference clock.
 assumes a host that frames commands with chip select and clocks data in on the rising link edge.
*/
`timescale 1ns/1ns
module dpd_top
    import dpd_pkg::*;
#(
    parameter int unsigned P_NV_WR_CYCLES = NV_WR_CYCLES
) (
    input wire logic i_ref_clk,
    input wire logic i_rst,
    input wire logic i_sck,
    input wire logic i_cs_n,
    input wire logic i_si,
    input wire logic [1:0] i_chip_addr,
    output logic o_so,
    output logic o_so_oe,
    output logic [WIPER_W-1:0] o_wiper_0,
    output logic [WIPER_W-1:0] o_wiper_1,
    output logic o_write_busy
);
    typedef enum logic [2:0] {
        ST_RECALL = 3'h1,
        ST_IDLE = 3'h2,
        ST_PEND = 3'h4
    } dpd_state_t;

    localparam int unsigned SNAP_W = 2 + 1 + NUM_POTS * NUM_SETTINGS * WIPER_W + NUM_POTS * WIPER_W;

    logic [NUM_POTS-1:0][WIPER_W-1:0] wiper_q;
    logic [NUM_POTS-1:0][NUM_SETTINGS-1:0][WIPER_W-1:0] stored_q;
    logic nv_busy;

    // link domain
    logic [4:0] cnt_q;
    logic [6:0] sh_q;
    logic match_q;
    logic cmd_ok_q;
    logic [7:0] rd_q;
    logic cmd_tgl_q;
    logic up_tgl_q;
    logic dn_tgl_q;
    dpd_op_t h_op_q;
    logic [1:0] h_idx_q;
    logic h_pot_q;
    logic [WIPER_W-1:0] h_data_q;
    logic [7:0] byte_now;
    dpd_op_t op_now;
    logic instr_take;
    logic step_on;
    logic [SNAP_W-1:0] snap_s;
    logic [1:0] addr_s;
    logic busy_s;
    logic [NUM_POTS-1:0][NUM_SETTINGS-1:0][WIPER_W-1:0] set_s;
    logic [NUM_POTS-1:0][WIPER_W-1:0] wip_s;

    assign byte_now = {sh_q, i_si};
    assign op_now = dpd_op_t'(byte_now[OP_MSB:OP_LSB]);
    assign instr_take = (cnt_q == CNT_INSTR_LAST) && match_q && dpd_instr_ok(byte_now);
    assign step_on = cmd_ok_q && (h_op_q == OP_STEP) && (cnt_q >= CNT_INSTR_DONE);
    assign {addr_s, busy_s, set_s, wip_s} = snap_s;

    dpd_sync #(
        .W(SNAP_W)
    ) u_snap_sync (
        .i_clk(i_sck),
        .i_d({i_chip_addr, nv_busy, stored_q, wiper_q}),
        .o_q(snap_s)
    );

    function automatic logic [7:0] read_value(input logic [7:0] instr);
        logic [7:0] v;
        v = 8'h00;
        case (instr[OP_MSB:OP_LSB])
            OP_RD_WIPER: v = {2'h0, wip_s[instr[POT_BIT]]};
            OP_RD_SET: v = {2'h0, set_s[instr[POT_BIT]][instr[IDX_MSB:IDX_LSB]]};
            OP_STATUS: v = {7'h00, busy_s};
            default: v = 8'h00;
        endcase
        return v;
    endfunction : read_value

    // frame position and address match, cleared whenever chip select is high
    always_ff @(posedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            cnt_q <= 5'h00;
            sh_q <= 7'h00;
            match_q <= 1'b0;
            cmd_ok_q <= 1'b0;
        end else begin
            sh_q <= byte_now[6:0];
            if (cnt_q != CNT_SAT) begin
                cnt_q <= cnt_q + 5'h01;
            end
            if (cnt_q == CNT_ADDR_LAST) begin
                match_q <= (byte_now == {DEVICE_CODE, addr_s});
            end
            if (instr_take) begin
                cmd_ok_q <= 1'b1;
            end
        end
    end

    // command hold words, read by the reference side after a command toggle, and h_pot_q also on step events
    always_ff @(posedge i_sck) begin
        if (instr_take) begin
            h_op_q <= op_now;
            h_idx_q <= byte_now[IDX_MSB:IDX_LSB];
            h_pot_q <= byte_now[POT_BIT];
        end
        if (cnt_q == CNT_DATA_LAST) begin
            h_data_q <= byte_now[WIPER_W-1:0];
        end
        if (instr_take) begin
            rd_q <= read_value(byte_now);
        end else begin
            rd_q <= {rd_q[6:0], 1'b0};
        end
    end

    // command and step events toward the reference side
    always_ff @(posedge i_sck or posedge i_rst) begin
        if (i_rst) begin
            cmd_tgl_q <= 1'b0;
            up_tgl_q <= 1'b0;
            dn_tgl_q <= 1'b0;
        end else begin
            if (instr_take && dpd_is_xfer(op_now)) begin
                cmd_tgl_q <= !cmd_tgl_q;
            end else if ((cnt_q == CNT_DATA_LAST) && cmd_ok_q && ((h_op_q == OP_WR_WIPER) || (h_op_q == OP_WR_SET))) begin
                cmd_tgl_q <= !cmd_tgl_q;
            end
            if (step_on && i_si) begin
                up_tgl_q <= !up_tgl_q;
            end
            if (step_on && !i_si) begin
                dn_tgl_q <= !dn_tgl_q;
            end
        end
    end

    // serial out changes on the falling edge, driven only during a read data byte
    always_ff @(negedge i_sck or posedge i_cs_n) begin
        if (i_cs_n) begin
            o_so <= 1'b0;
            o_so_oe <= 1'b0;
        end else begin
            o_so <= rd_q[7];
            o_so_oe <= cmd_ok_q && dpd_is_read(h_op_q) && (cnt_q >= CNT_INSTR_DONE) && (cnt_q < CNT_DATA_DONE);
        end
    end

    // reference domain
    logic cs_s;
    logic cmd_s;
    logic up_s;
    logic dn_s;
    logic cmd_p_q;
    logic up_p_q;
    logic dn_p_q;
    logic cmd_evt;
    logic up_evt;
    logic dn_evt;
    logic exec;
    logic nv_start;
    dpd_state_t state_q;
    dpd_op_t x_op_q;
    logic [1:0] x_idx_q;
    logic x_pot_q;
    logic [WIPER_W-1:0] x_data_q;

    dpd_sync #(
        .W(4)
    ) u_link_sync (
        .i_clk(i_ref_clk),
        .i_d({i_cs_n, cmd_tgl_q, up_tgl_q, dn_tgl_q}),
        .o_q({cs_s, cmd_s, up_s, dn_s})
    );

    assign cmd_evt = cmd_s ^ cmd_p_q;
    assign up_evt = up_s ^ up_p_q;
    assign dn_evt = dn_s ^ dn_p_q;
    assign exec = (state_q == ST_PEND) && cs_s;
    assign nv_start = exec && !nv_busy
        && ((x_op_q == OP_WR_SET) || (x_op_q == OP_XFR_W2S) || (x_op_q == OP_GXFR_W2S));

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            cmd_p_q <= 1'b0;
            up_p_q <= 1'b0;
            dn_p_q <= 1'b0;
        end else begin
            cmd_p_q <= cmd_s;
            up_p_q <= up_s;
            dn_p_q <= dn_s;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            state_q <= ST_RECALL;
        end else begin
            unique case (state_q)
                ST_RECALL: state_q <= ST_IDLE;
                ST_IDLE: state_q <= cmd_evt ? ST_PEND : ST_IDLE;
                ST_PEND: state_q <= cs_s ? ST_IDLE : ST_PEND;
                default: state_q <= ST_IDLE;
            endcase
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            x_op_q <= OP_STATUS;
            x_idx_q <= 2'b00;
            x_pot_q <= 1'b0;
            x_data_q <= WIPER_MIN;
        end else if (cmd_evt) begin
            x_op_q <= h_op_q;
            x_idx_q <= h_idx_q;
            x_pot_q <= h_pot_q;
            x_data_q <= h_data_q;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            wiper_q <= '0;
        end else if (state_q == ST_RECALL) begin
            for (int p = 0; p < NUM_POTS; p++) begin
                wiper_q[p] <= stored_q[p][0];
            end
        end else if (exec) begin
            case (x_op_q)
                OP_WR_WIPER: wiper_q[x_pot_q] <= x_data_q;
                OP_XFR_S2W: wiper_q[x_pot_q] <= stored_q[x_pot_q][x_idx_q];
                OP_GXFR_S2W: begin
                    for (int p = 0; p < NUM_POTS; p++) begin
                        wiper_q[p] <= stored_q[p][x_idx_q];
                    end
                end
                default: wiper_q <= wiper_q;
            endcase
        end else if (up_evt && !dn_evt && (wiper_q[h_pot_q] != WIPER_MAX)) begin
            wiper_q[h_pot_q] <= wiper_q[h_pot_q] + WIPER_STEP;
        end else if (dn_evt && !up_evt && (wiper_q[h_pot_q] != WIPER_MIN)) begin
            wiper_q[h_pot_q] <= wiper_q[h_pot_q] - WIPER_STEP;
        end
    end

    always_ff @(posedge i_ref_clk) begin
        if (i_rst) begin
            stored_q <= {(NUM_POTS * NUM_SETTINGS){STORED_RESET}};
        end else if (nv_start) begin
            case (x_op_q)
                OP_WR_SET: stored_q[x_pot_q][x_idx_q] <= x_data_q;
                OP_XFR_W2S: stored_q[x_pot_q][x_idx_q] <= wiper_q[x_pot_q];
                OP_GXFR_W2S: begin
                    for (int p = 0; p < NUM_POTS; p++) begin
                        stored_q[p][x_idx_q] <= wiper_q[p];
                    end
                end
                default: stored_q <= stored_q;
            endcase
        end
    end

    dpd_nv_timer #(
        .CYCLES(P_NV_WR_CYCLES)
    ) u_nv_timer (
        .i_ref_clk(i_ref_clk),
        .i_rst(i_rst),
        .i_start(nv_start),
        .o_busy(nv_busy)
    );

    assign o_wiper_0 = wiper_q[0];
    assign o_wiper_1 = wiper_q[1];
    assign o_write_busy = nv_busy;

    // checks
    property p_step_up;
        @(posedge i_ref_clk) disable iff (i_rst)
        (state_q == ST_IDLE && up_evt && !dn_evt && wiper_q[h_pot_q] != WIPER_MAX)
        |=> (wiper_q[$past(h_pot_q)] == $past(wiper_q[h_pot_q]) + WIPER_STEP);
    endproperty
    a_step_up: assert property (p_step_up) else $error("wiper did not step up");

    property p_step_dn;
        @(posedge i_ref_clk) disable iff (i_rst)
        (state_q == ST_IDLE && dn_evt && !up_evt && wiper_q[h_pot_q] != WIPER_MIN)
        |=> (wiper_q[$past(h_pot_q)] == $past(wiper_q[h_pot_q]) - WIPER_STEP);
    endproperty
    a_step_dn: assert property (p_step_dn) else $error("wiper did not step down");

    property p_sat_hi;
        @(posedge i_ref_clk) disable iff (i_rst)
        (state_q == ST_IDLE && up_evt && !dn_evt && wiper_q[h_pot_q] == WIPER_MAX) |=> $stable(wiper_q);
    endproperty
    a_sat_hi: assert property (p_sat_hi) else $error("wiper wrapped past top");

    property p_addr;
        @(posedge i_sck) disable iff (i_rst) !match_q |=> $stable(cmd_tgl_q);
    endproperty
    a_addr: assert property (p_addr) else $error("command taken with wrong address");

    property p_short;
        @(posedge i_sck) disable iff (i_rst)
        (cnt_q != CNT_INSTR_LAST && cnt_q != CNT_DATA_LAST) |=> $stable(cmd_tgl_q);
    endproperty
    a_short: assert property (p_short) else $error("command taken at wrong bit count");

    property p_status;
        @(posedge i_sck) disable iff (i_rst || i_cs_n)
        (cnt_q == CNT_INSTR_DONE && cmd_ok_q && h_op_q == OP_STATUS) |-> (rd_q[7:1] == 7'h00);
    endproperty
    a_status: assert property (p_status) else $error("status upper bits not zero");

    property p_nv_cs;
        @(posedge i_ref_clk) disable iff (i_rst) nv_start |-> (cs_s && state_q == ST_PEND);
    endproperty
    a_nv_cs: assert property (p_nv_cs) else $error("write cycle before chip select high");

    property p_recall;
        @(posedge i_ref_clk) disable iff (i_rst)
        (state_q == ST_RECALL) |=> (wiper_q[0] == $past(stored_q[0][0]) && wiper_q[1] == $past(stored_q[1][0]));
    endproperty
    a_recall: assert property (p_recall) else $error("wiper not recalled from setting zero");

    property p_wr_wiper;
        @(posedge i_ref_clk) disable iff (i_rst)
        (exec && x_op_q == OP_WR_WIPER) |=> (wiper_q[$past(x_pot_q)] == $past(x_data_q));
    endproperty
    a_wr_wiper: assert property (p_wr_wiper) else $error("wiper write lost");

    property p_gw2s;
        @(posedge i_ref_clk) disable iff (i_rst)
        (nv_start && x_op_q == OP_GXFR_W2S)
        |=> (stored_q[0][$past(x_idx_q)] == $past(wiper_q[0]) && stored_q[1][$past(x_idx_q)] == $past(wiper_q[1]));
    endproperty
    a_gw2s: assert property (p_gw2s) else $error("global copy to settings wrong");
endmodule : dpd_top

// ### sim/dpd_spi_host.sv
/*
 serial host model: frames commands with chip select, clocks bits out msb first, reads the answer.
 assumes a mode 0 link with a 125 ns clock that stands still low between frames.
*/
`timescale 1ns/1ns
module dpd_spi_host (
    output logic o_sck,
    output logic o_cs_n,
    output logic o_si,
    input wire logic i_so,
    input wire logic i_so_oe
);
    // chip select rises from unknown just after time zero so the frame logic starts cleared
    initial begin
        o_sck = 1'b0;
        o_si = 1'b0;
        #1;
        o_cs_n = 1'b1;
    end

    // sends the n low bits of bits, msb first; bits 17 to 24 are read back
    task automatic xfer(input logic [63:0] bits, input int n, output logic [7:0] rd);
        int i;
        rd = 8'h00;
        o_cs_n = 1'b0;
        #57;
        for (i = 0; i < n; i++) begin
            o_si = bits[n-1-i];
            #30;
            o_sck = 1'b1;
            if (i >= 16 && i < 24) begin
                rd = {rd[6:0], (i_so_oe === 1'b1) ? i_so : 1'bx};
            end
            #62;
            o_sck = 1'b0;
            #33;
        end
        #40;
        o_cs_n = 1'b1;
        o_si = ~o_si;
    endtask : xfer
endmodule : dpd_spi_host

// ### sim/tb_top.sv
/*
 testbench of the dual pot command decoder: command sequences through the serial host model.
 assumes a shortened write cycle of 200 reference clocks and chip address 2.
*/
`timescale 1ns/1ns
`define CHK(a, b) begin comparisons++; if ((a) !== (b)) begin failures++; \
    $display("CHECK FAILED %0t value mismatch", $time); end end
module tb_top;
    import dpd_pkg::*;
    localparam int unsigned NV = 200;
    localparam logic [1:0] ADDR = 2'h2;
    logic i_ref_clk = 1'b0;
    logic i_rst;
    logic sck, cs_n, si, so, so_oe, busy;
    logic [5:0] w0, w1;
    logic [1:0] addr = ADDR;
    logic [7:0] rd;
    int failures = 0;
    int comparisons = 0;
    int i;

    always #25 i_ref_clk = ~i_ref_clk;

    dpd_top #(.P_NV_WR_CYCLES(NV)) i_dut (.i_ref_clk(i_ref_clk), .i_rst(i_rst), .i_sck(sck), .i_cs_n(cs_n),
        .i_si(si), .i_chip_addr(ADDR), .o_so(so), .o_so_oe(so_oe), .o_wiper_0(w0), .o_wiper_1(w1),
        .o_write_busy(busy));
    dpd_spi_host i_host (.o_sck(sck), .o_cs_n(cs_n), .o_si(si), .i_so(so), .i_so_oe(so_oe));

    task automatic complete_run;
        $display("comparisons %0d failures %0d", comparisons, failures);
        if (failures == 0 && comparisons > 0) begin
            $display("DONE - PASS");
        end else begin
            $display("DONE - FAIL");
        end
        $finish;
    endtask : complete_run

    // waits for the write cycle and measures its length
    task automatic nv_cycle;
        int c;
        c = 0;
        `CHK(busy, 1'b0)
        repeat (20) if (busy !== 1'b1) @(negedge i_ref_clk);
        while (busy === 1'b1 && c < NV + 10) begin
            c++;
            @(negedge i_ref_clk);
        end
        `CHK(c >= NV && c <= NV + 1, 1'b1)
    endtask : nv_cycle

    // mode 0: plain, busy stays low; mode 1: write cycle follows; mode 2: short settle only
    task automatic cmd(input logic [3:0] op, input logic [1:0] idx, input logic pot, input logic [7:0] data,
        input int n, input int mode);
        logic [63:0] v;
        v = {40'h0, DEVICE_CODE, addr, op, idx, 1'b0, pot, data} >> (24 - n);
        i_host.xfer(v, n, rd);
        if (mode == 1) begin
            nv_cycle();
        end else if (mode == 2) begin
            repeat (8) @(negedge i_ref_clk);
        end else begin
            repeat (10) @(negedge i_ref_clk);
            `CHK(busy, 1'b0)
        end
    endtask : cmd

    task automatic step(input logic pot, input logic [7:0] dirs, input int k);
        logic [63:0] v;
        v = {40'h0, DEVICE_CODE, addr, OP_STEP, 3'h0, pot, dirs} >> (8 - k);
        i_host.xfer(v, 16 + k, rd);
        repeat (10) @(negedge i_ref_clk);
    endtask : step

    initial begin
        #1_000_000;
        failures++;
        complete_run();
    end

    initial begin
        #1;
        i_rst = 1'b1;
        repeat (5) @(negedge i_ref_clk);
        i_rst = 1'b0;
        repeat (6) @(negedge i_ref_clk);
        `CHK(w0, STORED_RESET)
        `CHK(w1, STORED_RESET)
        `CHK(busy, 1'b0)
        $display("test reset done");

        cmd(OP_WR_WIPER, 2'h0, 1'b1, 8'h15, 24, 0);
        `CHK(w1, 6'h15)
        cmd(OP_RD_WIPER, 2'h0, 1'b1, 8'h00, 24, 0);
        `CHK(rd, 8'h15)
        addr = ~ADDR;
        cmd(OP_WR_WIPER, 2'h0, 1'b1, 8'h2A, 24, 0);
        addr = ADDR;
        `CHK(w1, 6'h15)
        cmd(OP_WR_WIPER, 2'h0, 1'b1, 8'h2A, 20, 0);
        `CHK(w1, 6'h15)
        $display("test wiper done");

        cmd(OP_WR_SET, 2'h2, 1'b0, 8'h0A, 24, 2);
        cmd(OP_STATUS, 2'h0, 1'b1, 8'h00, 24, 2);
        `CHK(rd, 8'h01)
        repeat (NV + 20) @(negedge i_ref_clk);
        cmd(OP_STATUS, 2'h0, 1'b1, 8'h00, 24, 0);
        `CHK(rd, 8'h00)
        cmd(OP_RD_SET, 2'h2, 1'b0, 8'h00, 24, 0);
        `CHK(rd, 8'h0A)
        cmd(OP_XFR_W2S, 2'h3, 1'b1, 8'h00, 16, 1);
        for (i = 0; i < 4; i++) begin
            cmd(OP_RD_SET, i[1:0], 1'b1, 8'h00, 24, 0);
            `CHK(rd, (i == 3) ? 8'h15 : {2'h0, STORED_RESET})
        end
        $display("test setting done");

        cmd(OP_XFR_S2W, 2'h2, 1'b0, 8'h00, 16, 0);
        `CHK(w0, 6'h0A)
        cmd(OP_GXFR_W2S, 2'h1, 1'b0, 8'h00, 16, 1);
        cmd(OP_WR_WIPER, 2'h0, 1'b0, 8'h3E, 24, 0);
        cmd(OP_WR_WIPER, 2'h0, 1'b1, 8'h01, 24, 0);
        cmd(OP_GXFR_S2W, 2'h1, 1'b0, 8'h00, 16, 0);
        `CHK(w0, 6'h0A)
        `CHK(w1, 6'h15)
        $display("test transfer done");

        cmd(OP_WR_WIPER, 2'h0, 1'b0, 8'h3E, 24, 0);
        cmd(OP_WR_WIPER, 2'h0, 1'b1, 8'h01, 24, 0);
        step(1'b0, 8'hE0, 5);
        `CHK(w0, 6'h3D)
        step(1'b1, 8'h00, 3);
        `CHK(w1, WIPER_MIN)
        step(1'b1, 8'h80, 1);
        `CHK(w1, WIPER_STEP)
        `CHK(w0, 6'h3D)
        $display("test step done");
        complete_run();
    end
endmodule : tb_top
